//--- ptr_card.sv
// Card end: reference select, trigger output routing, inputs and ready line
`default_nettype none
`include "ptr_map.svh"

// Operation
// - register chooses internal or backplane reference
// - routed trigger no longer triggers card
// - route codes 0 none, 1-6 lines, 9 star
// - rising edge, low again at stop
// - availability bitmap marks lines 0-5, star
// - lines 0-5 usable as input/output
// - line 7 only for card coordination
// - line 7 signals pretrigger done, ready
// - line 7 open collector, pulled up
// - detection enabled only while line 7 high
// - all drivers high impedance after reset
// - software avoids two drivers per line
// - sources and one driver set by software
// - star only with star trigger card
// - no phase guarantee across cards
// - routing independent of other settings
// - input sources ORed bitmap, zero internal
module ptr_card (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Backplane
  ptr_link_if.card         link,
  // Acquisition core
  input  wire logic        intTrig,
  input  wire logic        acqRunning,
  input  wire logic        pretrigDone,
  output logic             refUseBackplane,
  output logic             refClkSync,
  output logic             trigToCore,
  output logic             detectEnable
);
  ptr_pkg::ptr_word_t   refSel_ff, inSrc_ff, nxt_prdata;
  logic [3:0]           route_ff;
  logic [1:0]           ctrl_ff;
  logic [5:0]           lineOut_ff;
  logic                 starOut_ff, prevTrig_ff, bad;
  logic [8:0]           s1In_ff, s2In_ff;
  logic [1:0]           s1Misc_ff, s2Misc_ff;
  logic                 trigFired;
  logic                 readyLow_ff;
  ptr_pkg::ptr_state_e  state_ff;
  logic [15:0]          idx;

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  // Registers sit at four times their printed index
  assign idx     = paddr[17:2];
  assign pready  = 1'b1;
  assign pslverr = psel & penable & bad;

  // Unmapped index, or write to a read-only word
  function automatic logic badAccess(input logic [15:0] i, input logic wr);
    if (i == `PTR_IDX_REFCLK_SEL) begin
      badAccess = 1'b0;
    end else if (i == `PTR_IDX_TRG_OUT_ROUTE) begin
      badAccess = 1'b0;
    end else if (i == `PTR_IDX_TRG_IN_SOURCES) begin
      badAccess = 1'b0;
    end else if (i == `PTR_IDX_CONTROL) begin
      badAccess = 1'b0;
    end else if (i == `PTR_IDX_TRG_OUT_AVAIL || i == `PTR_IDX_STATUS) begin
      badAccess = wr;
    end else begin
      badAccess = 1'b1;
    end
  endfunction
  assign bad = badAccess(idx, pwrite);

  // Register writes; these words touch nothing else in the card
  // routing settings stand alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refSel_ff <= `PTR_RST_WORD;
      route_ff  <= `PTR_ROUTE_NONE;
      inSrc_ff  <= `PTR_RST_WORD;
      ctrl_ff   <= 2'b00;
    end else if (psel && penable && pwrite && !bad) begin
      if (idx == `PTR_IDX_REFCLK_SEL) begin
        refSel_ff <= pwdata;
      end else if (idx == `PTR_IDX_TRG_OUT_ROUTE) begin
        route_ff <= pwdata[3:0];
      end else if (idx == `PTR_IDX_TRG_IN_SOURCES) begin
        // unsupported source bits read back zero
        inSrc_ff <= pwdata & `PTR_IN_LINE_MASK;
      end else if (idx == `PTR_IDX_CONTROL) begin
        ctrl_ff <= pwdata[1:0];
      end
    end
  end

  // Read mux, registered so data stays stable through the access phase
  always_comb begin
    nxt_prdata = '0;
    if (idx == `PTR_IDX_REFCLK_SEL) begin
      nxt_prdata = refSel_ff;
    end else if (idx == `PTR_IDX_TRG_OUT_ROUTE) begin
      nxt_prdata = {28'h000_0000, route_ff};
    end else if (idx == `PTR_IDX_TRG_OUT_AVAIL) begin
      nxt_prdata = `PTR_OUT_AVAIL_VALUE;
    end else if (idx == `PTR_IDX_TRG_IN_SOURCES) begin
      nxt_prdata = inSrc_ff;
    end else if (idx == `PTR_IDX_STATUS) begin
      nxt_prdata = {20'h0_0000, state_ff, s2Misc_ff[1], s2In_ff};
    end else if (idx == `PTR_IDX_CONTROL) begin
      nxt_prdata = {30'h0000_0000, ctrl_ff};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= nxt_prdata;
    end
  end

  // --------------------------------------------------------------------
  // Reference clock
  // --------------------------------------------------------------------
  // all-ones word picks the backplane reference; phase is not aligned
  assign refUseBackplane = (refSel_ff == `PTR_REFCLK_BACKPLANE);

  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  // two flops before any use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1In_ff   <= '0;
      s2In_ff   <= '0;
      s1Misc_ff <= 2'b00;
      s2Misc_ff <= 2'b00;
    end else begin
      s1In_ff   <= {link.starIn, 2'b00, link.trgIn};
      s2In_ff   <= s1In_ff;
      s1Misc_ff <= {link.readyIn, link.refClk};
      s2Misc_ff <= s1Misc_ff;
    end
  end
  assign refClkSync = s2Misc_ff[0];

  // --------------------------------------------------------------------
  // Trigger output
  // --------------------------------------------------------------------
  // Acquisition state: fired latch ends when the acquisition stops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff    <= ptr_pkg::PTR_IDLE;
      prevTrig_ff <= 1'b0;
    end else begin
      prevTrig_ff <= intTrig;
      case (state_ff)
        ptr_pkg::PTR_IDLE: begin
          if (acqRunning) begin
            state_ff <= ptr_pkg::PTR_ARMED;
          end
        end
        ptr_pkg::PTR_ARMED: begin
          if (!acqRunning) begin
            state_ff <= ptr_pkg::PTR_IDLE;
          end else if (intTrig && !prevTrig_ff && detectEnable) begin
            state_ff <= ptr_pkg::PTR_FIRED;
          end
        end
        default: begin
          if (!acqRunning) begin
            state_ff <= ptr_pkg::PTR_IDLE;
          end
        end
      endcase
    end
  end

  assign trigFired = (state_ff == ptr_pkg::PTR_FIRED);

  // Drive data and enables; a route code outside the set drives nothing
  // decode route code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lineOut_ff <= '0;
      starOut_ff <= 1'b0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        lineOut_ff[i] <= (route_ff == 4'(i + 1));
      end
      starOut_ff <= (route_ff == `PTR_ROUTE_STAR);
    end
  end

  assign link.trgOe   = lineOut_ff;
  assign link.trgOut  = lineOut_ff & {6{trigFired}};
  assign link.starOe  = starOut_ff;
  assign link.starOut = starOut_ff & trigFired;

  // --------------------------------------------------------------------
  // Trigger input and ready line
  // --------------------------------------------------------------------
  // hold line 7 low until pretrigger done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readyLow_ff <= 1'b0;
    end else begin
      readyLow_ff <= ctrl_ff[`PTR_CTRL_ARM_BIT] & ~pretrigDone;
    end
  end
  // line 7 used for coordination only
  assign link.readyLowOe = readyLow_ff;

  assign detectEnable = s2Misc_ff[1];

  // routed trigger is withheld from self
  always_comb begin
    if (inSrc_ff == `PTR_RST_WORD) begin
      trigToCore = (route_ff == `PTR_ROUTE_NONE) & intTrig & detectEnable;
    end else begin
      trigToCore = (|(inSrc_ff[8:0] & s2In_ff)) & detectEnable;
    end
  end
endmodule
`default_nettype wire

//--- ptr_chassis.sv
// Far end: other cards and star trigger card driving the backplane
`default_nettype none
`include "ptr_map.svh"
module ptr_chassis #(
  parameter int REF_DIV = 5
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Backplane
  ptr_link_if.chassis     link,
  // User side
  input  wire logic [5:0] userLineOe,
  input  wire logic [5:0] userLineVal,
  input  wire logic       userStarOe,
  input  wire logic       userStarVal,
  input  wire logic       userNotReady,
  output logic      [5:0] seenLines,
  output logic            seenStar,
  output logic            seenReady
);
  logic [5:0] lineOe_ff, lineVal_ff, s1Lines_ff, s2Lines_ff;
  logic       starOe_ff, starVal_ff, holdLow_ff, refClk_ff;
  logic [1:0] s1Misc_ff, s2Misc_ff;
  logic [7:0] div_ff;

  // --------------------------------------------------------------------
  // Drivers
  // --------------------------------------------------------------------
  // released after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lineOe_ff  <= '0;
      lineVal_ff <= '0;
      starOe_ff  <= 1'b0;
      starVal_ff <= 1'b0;
      holdLow_ff <= 1'b0;
    end else begin
      lineOe_ff  <= userLineOe;
      lineVal_ff <= userLineVal;
      // star used only with star card
      starOe_ff  <= userStarOe;
      starVal_ff <= userStarVal;
      holdLow_ff <= userNotReady;
    end
  end

  assign link.farOut        = lineVal_ff;
  assign link.farOe         = lineOe_ff;
  assign link.farStarOut    = starVal_ff;
  assign link.farStarOe     = starOe_ff;
  assign link.farReadyLowOe = holdLow_ff;

  // 10 MHz reference derived by a divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff    <= '0;
      refClk_ff <= 1'b0;
    end else if (div_ff == 8'(REF_DIV - 1)) begin
      div_ff    <= '0;
      refClk_ff <= ~refClk_ff;
    end else begin
      div_ff <= div_ff + 8'd1;
    end
  end
  assign link.refClk = refClk_ff;

  // Observe the wired lines through two flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1Lines_ff <= '0;
      s2Lines_ff <= '0;
      s1Misc_ff  <= 2'b00;
      s2Misc_ff  <= 2'b00;
    end else begin
      s1Lines_ff <= link.trgIn;
      s2Lines_ff <= s1Lines_ff;
      s1Misc_ff  <= {link.readyIn, link.starIn};
      s2Misc_ff  <= s1Misc_ff;
    end
  end
  assign seenLines = s2Lines_ff;
  assign seenStar  = s2Misc_ff[0];
  assign seenReady = s2Misc_ff[1];
endmodule
`default_nettype wire

//--- ptr_link_if.sv
// Backplane pins between the card and the rest of the chassis
`default_nettype none
interface ptr_link_if;
  // Trigger lines 0-5: five signals each
  logic [5:0] trgIn;
  logic [5:0] trgOut;
  logic [5:0] trgOe;
  logic [5:0] farOut;
  logic [5:0] farOe;
  // Star line
  logic       starIn;
  logic       starOut;
  logic       starOe;
  logic       farStarOut;
  logic       farStarOe;
  // Open-collector ready line 7
  logic       readyIn;
  logic       readyLowOe;
  logic       farReadyLowOe;
  // Backplane reference clock
  logic       refClk;

  // Resolve wired levels; undriven lines idle low, line 7 pulls high
  assign trgIn   = (trgOe & trgOut) | (farOe & farOut);
  assign starIn  = (starOe & starOut) | (farStarOe & farStarOut);
  assign readyIn = ~(readyLowOe | farReadyLowOe);

  modport card (
    input  trgIn, starIn, readyIn, refClk,
    output trgOut, trgOe, starOut, starOe, readyLowOe
  );
  modport chassis (
    input  trgIn, starIn, readyIn,
    output farOut, farOe, farStarOut, farStarOe, farReadyLowOe, refClk
  );
endinterface
`default_nettype wire

//--- ptr_map.svh
// Register offsets, field encodings and reset values of the backplane routing block
`ifndef PTR_MAP_SVH
`define PTR_MAP_SVH

// Register offsets (printed offsets are indices; byte address is index * 4)
`define PTR_IDX_REFCLK_SEL      16'h4eac
`define PTR_IDX_TRG_OUT_ROUTE   16'h9d6c
`define PTR_IDX_TRG_OUT_AVAIL   16'h9d6d
`define PTR_IDX_TRG_IN_SOURCES  16'h9d70
`define PTR_IDX_STATUS          16'h9d71
`define PTR_IDX_CONTROL         16'h9d72

// Reference clock selection values
`define PTR_REFCLK_INTERNAL     32'h0000_0000
`define PTR_REFCLK_BACKPLANE    32'hffff_ffff

// Output route encodings
`define PTR_ROUTE_NONE          4'h0
`define PTR_ROUTE_LINE_FIRST    4'h1
`define PTR_ROUTE_LINE_LAST     4'h6
`define PTR_ROUTE_STAR          4'h9

// Output availability: lines 0-5 and star
`define PTR_OUT_AVAIL_VALUE     32'h0000_013f

// Input source bitmap fields
`define PTR_IN_STAR_BIT         8
`define PTR_IN_LINE_MASK        32'h0000_013f

// Control register fields
`define PTR_CTRL_ARM_BIT        0
`define PTR_CTRL_PRETRIG_BIT    1

// Reset values
`define PTR_RST_WORD            32'h0000_0000

`endif

//--- ptr_pkg.sv
// Types used by the card end of the backplane routing link
`default_nettype none
package ptr_pkg;
  typedef enum logic [1:0] {
    PTR_IDLE,
    PTR_ARMED,
    PTR_FIRED
  } ptr_state_e;
  typedef logic [31:0] ptr_word_t;
endpackage
`default_nettype wire

//--- ptr_properties.sv
// Concurrent checks on the backplane link between card and chassis
`default_nettype none
module ptr_properties #(
  parameter int REF_DIV = 5
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Trigger lines and star
  input wire logic [5:0] trgIn,
  input wire logic [5:0] trgOut,
  input wire logic [5:0] trgOe,
  input wire logic [5:0] farOut,
  input wire logic [5:0] farOe,
  input wire logic       starIn,
  input wire logic       starOut,
  input wire logic       starOe,
  input wire logic       farStarOut,
  input wire logic       farStarOe,
  // Ready line and reference
  input wire logic       readyIn,
  input wire logic       readyLowOe,
  input wire logic       farReadyLowOe,
  input wire logic       refClk
);
  default clocking @(posedge clk); endclocking
  logic [7:0] gapCnt_ff;
  logic       refSeen_ff;

  // Cycles since the last reference edge; the first edge after reset is not timed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gapCnt_ff  <= 8'h00;
      refSeen_ff <= 1'b0;
    end else if ($changed(refClk)) begin
      gapCnt_ff  <= 8'h00;
      refSeen_ff <= 1'b1;
    end else begin
      gapCnt_ff <= gapCnt_ff + 8'h01;
    end
  end

  a_card_reset_quiet: assert property (rst |-> !trgOe && !starOe && !readyLowOe)
    else $error("card drives backplane in reset");
  a_far_reset_quiet: assert property (rst |-> !farOe && !farStarOe && !farReadyLowOe)
    else $error("far end drives backplane in reset");
  a_single_route: assert property (disable iff (rst) $onehot0({starOe, trgOe}))
    else $error("more than one output line enabled");
  a_route_hold: assert property (disable iff (rst) $changed({starOe, trgOe}) |=>
    $stable({starOe, trgOe})) else $error("route enables changed twice in a row");
  a_ref_half_period: assert property (disable iff (rst)
    $changed(refClk) && refSeen_ff |-> gapCnt_ff == REF_DIV - 1)
    else $error("reference half period wrong");
  a_ref_not_stuck: assert property (disable iff (rst) gapCnt_ff <= REF_DIV)
    else $error("reference clock stalled");
  a_ready_wired_and: assert property (disable iff (rst)
    readyIn == !(readyLowOe || farReadyLowOe)) else $error("line 7 level wrong");
  a_trig_wired_or: assert property (disable iff (rst)
    trgIn == ((trgOe & trgOut) | (farOe & farOut))) else $error("trigger line level wrong");
  a_star_wired_or: assert property (disable iff (rst)
    starIn == ((starOe & starOut) | (farStarOe & farStarOut))) else $error("star level wrong");
  a_ready_after_reset: assert property ($fell(rst) |-> readyIn)
    else $error("line 7 held low after reset");
  a_trig_only_enabled: assert property (disable iff (rst)
    (trgOut & ~trgOe) == 6'h00) else $error("trigger data on a released line");
  a_star_only_enabled: assert property (disable iff (rst)
    !starOut || starOe) else $error("star data while released");
endmodule
`default_nettype wire

//--- test_pxi_trigger_clock_routing.sv
// Self-checking bench joining card and chassis across the backplane
`default_nettype none
`include "ptr_map.svh"
module test_pxi_trigger_clock_routing;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0_0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
  logic        pready, pslverr, perr, refUse, refSync, trigToCore, detectEnable;
  logic        intTrig = 1'b0, acqRunning = 1'b0, pretrigDone = 1'b1;
  logic [5:0]  userLineOe = 6'h00, userLineVal = 6'h00, seenLines;
  logic        userStarOe = 1'b0, userStarVal = 1'b0, userNotReady = 1'b0, seenStar, seenReady;
  int          errorCnt = 0, nChecks = 0;

  ptr_link_if link ();
  ptr_card ptr_card_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.card), .intTrig(intTrig), .acqRunning(acqRunning),
    .pretrigDone(pretrigDone), .refUseBackplane(refUse), .refClkSync(refSync),
    .trigToCore(trigToCore), .detectEnable(detectEnable));
  ptr_chassis #(.REF_DIV(5)) ptr_chassis_inst (.clk(clk), .rst(rst), .link(link.chassis),
    .userLineOe(userLineOe), .userLineVal(userLineVal), .userStarOe(userStarOe),
    .userStarVal(userStarVal), .userNotReady(userNotReady), .seenLines(seenLines),
    .seenStar(seenStar), .seenReady(seenReady));
  ptr_properties #(.REF_DIV(5)) ptr_properties_inst (.clk(clk), .rst(rst),
    .trgIn(link.trgIn), .trgOut(link.trgOut), .trgOe(link.trgOe), .farOut(link.farOut),
    .farOe(link.farOe), .starIn(link.starIn), .starOut(link.starOut), .starOe(link.starOe),
    .farStarOut(link.farStarOut), .farStarOe(link.farStarOe), .readyIn(link.readyIn),
    .readyLowOe(link.readyLowOe), .farReadyLowOe(link.farReadyLowOe), .refClk(link.refClk));

  // Free-running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer, request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sample just after an edge so that its updates have landed
  task automatic see(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    xfer(1'b0, `PTR_IDX_REFCLK_SEL, 32'h0); check(rdata, 32'h0, "ref reset");
    xfer(1'b1, `PTR_IDX_TRG_OUT_AVAIL, 32'h0); check(perr, 32'h1, "ro write");
    xfer(1'b0, `PTR_IDX_TRG_OUT_AVAIL, 32'h0); check(rdata, 32'h0000_013f, "avail");
    xfer(1'b0, 16'h1234, 32'h0); check(perr, 32'h1, "unmapped");
    check(link.trgOe, 32'h0, "lines idle");
  endtask

  // Only the all-ones word picks the backplane reference
  task automatic t_refclk();
    logic r0;
    xfer(1'b1, `PTR_IDX_REFCLK_SEL, 32'hffff_ffff);
    see(1); check(refUse, 32'h1, "backplane ref");
    // Reference level reaches the core two flops late
    r0 = link.refClk;
    see(2); check(refSync, r0, "ref synced");
    xfer(1'b1, `PTR_IDX_REFCLK_SEL, 32'h0000_0001);
    see(1); check(refUse, 32'h0, "internal ref");
  endtask

  // Route codes 0 to 10, reserved codes 7, 8 and 10 included
  task automatic t_routes();
    logic [6:0] e;
    for (int v = 0; v < 11; v++) begin
      e = (v == 9) ? 7'h40 : (v > 0 && v < 7) ? 7'(1 << (v - 1)) : 7'h00;
      xfer(1'b1, `PTR_IDX_TRG_OUT_ROUTE, 32'(v));
      see(2); check({link.starOe, link.trgOe}, {25'h0, e}, "route enables");
    end
  endtask

  // Routed trigger rises on its line, is withheld from the card, falls at stop
  task automatic t_trig_out();
    xfer(1'b1, `PTR_IDX_TRG_OUT_ROUTE, 32'h2);
    @(posedge clk);
    acqRunning <= 1'b1;
    see(3); check(detectEnable, 32'h1, "detect on");
    @(posedge clk);
    intTrig <= 1'b1;
    see(3); check(link.trgOut[1] & link.trgOe[1], 32'h1, "line rises");
    check(trigToCore, 32'h0, "withheld");
    see(2); check(seenLines, 32'h2, "far sees line");
    // Status: fired state, line 7 high, line 1 seen
    xfer(1'b0, `PTR_IDX_STATUS, 32'h0); check(rdata, 32'h0000_0a02, "status fired");
    acqRunning <= 1'b0;
    intTrig <= 1'b0;
    see(3); check(link.trgOut[1] & link.trgOe[1], 32'h0, "low at stop");
    xfer(1'b1, `PTR_IDX_TRG_OUT_ROUTE, 32'h0);
    @(posedge clk);
    acqRunning <= 1'b1;
    see(3);
    @(posedge clk);
    intTrig <= 1'b1;
    see(1); check(trigToCore, 32'h1, "self trigger");
    @(posedge clk);
    acqRunning <= 1'b0;
    intTrig <= 1'b0;
  endtask

  // Selected backplane sources are ORed, after synchronising
  task automatic t_inputs();
    xfer(1'b1, `PTR_IDX_TRG_IN_SOURCES, 32'h0000_0024);
    @(posedge clk);
    userLineOe <= 6'h3f;
    userLineVal <= 6'h04;
    see(4); check(trigToCore, 32'h1, "line 2 source");
    @(posedge clk);
    userLineVal <= 6'h02;
    see(4); check(trigToCore, 32'h0, "unselected");
    @(posedge clk);
    userLineVal <= 6'h20;
    see(4); check(trigToCore, 32'h1, "line 5 source");
    xfer(1'b1, `PTR_IDX_TRG_IN_SOURCES, 32'h0000_0100);
    userLineOe <= 6'h00;
    userStarOe <= 1'b1;
    userStarVal <= 1'b1;
    see(4); check(trigToCore, 32'h1, "star source");
    check(seenStar, 32'h1, "far sees star");
    @(posedge clk);
    userStarOe <= 1'b0;
    xfer(1'b1, `PTR_IDX_TRG_IN_SOURCES, 32'h0);
  endtask

  // Line 7 is held low by any card still in its pretrigger period
  task automatic t_ready();
    xfer(1'b1, `PTR_IDX_CONTROL, 32'h1);
    pretrigDone <= 1'b0;
    see(4); check(link.readyIn, 32'h0, "line 7 held");
    check(detectEnable, 32'h0, "detect off");
    check(seenReady, 32'h0, "far sees hold");
    @(posedge clk);
    pretrigDone <= 1'b1;
    see(4); check(detectEnable, 32'h1, "detect back");
    @(posedge clk);
    userNotReady <= 1'b1;
    see(4); check(detectEnable, 32'h0, "far card holds");
    xfer(1'b0, `PTR_IDX_CONTROL, 32'h0); check(rdata, 32'h1, "control back");
    userNotReady <= 1'b0;
  endtask

  // A reset in mid-run releases the star and trigger line enables and clears the route
  task automatic t_reset();
    xfer(1'b1, `PTR_IDX_TRG_OUT_ROUTE, 32'h9);
    see(2); check({link.starOe, link.trgOe}, 32'h40, "star driven");
    @(posedge clk);
    rst <= 1'b1;
    see(1); check({link.starOe, link.trgOe}, 32'h0, "released");
    @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, `PTR_IDX_TRG_OUT_ROUTE, 32'h0); check(rdata, 32'h0, "route cleared");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Main sequence; reset rises at time zero so async resets see an edge
  initial begin
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_refclk();
    t_routes();
    t_trig_out();
    t_inputs();
    t_ready();
    t_reset();
    final_report();
  end

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    final_report();
  end
endmodule
`default_nettype wire
